// >>> shared/clock_divider_pkg.sv
// ==========================================================================
package clock_divider_pkg;
   localparam logic [15:0] CLOCK_DIVIDE_CONTROL_OFFSET = 16'hFF5D;
   // The printed offset is odd, so it is kept as a word index and the bus
   // sees the register at four times that index, one aligned word.
   localparam logic [31:0] CLOCK_DIVIDE_CONTROL_ADDR = 32'h0003FD74;
   localparam logic [7:0] CLOCK_DIVIDE_CONTROL_RESET = 8'hFC;
   localparam logic [7:0] RESERVED_READ_MASK = 8'hFC;
   localparam int DIVIDE_SELECT_LOW_BIT = 0;
   localparam int DIVIDE_SELECT_HIGH_BIT = 1;
   localparam int DIVIDE_SELECT_WIDTH = 2;
   localparam logic [1:0] DIVIDE_BY_1 = 2'h0;
   localparam logic [1:0] DIVIDE_BY_2 = 2'h1;
   localparam logic [1:0] DIVIDE_BY_4 = 2'h2;
   localparam logic [1:0] DIVIDE_BY_8 = 2'h3;
   localparam int DIV_COUNT_WIDTH = 3;
   localparam int STANDBY_WAIT_DEFAULT = 16;
endpackage

// >>> core/divided_clock_gen.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Divider core
// The counter runs on the source clock; the divided clock is a registered
// enable pattern plus a registered level. A new select is only latched when
// the counter wraps, so no high or low phase of the output is cut short.
module divided_clock_gen
   import clock_divider_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] select,
   output logic sys_clk_level,
   output logic sys_clk_tick,
   output logic [1:0] active_select
);
   logic [DIV_COUNT_WIDTH-1:0] count_r;
   logic [DIV_COUNT_WIDTH-1:0] count_nxt;
   logic [DIV_COUNT_WIDTH-1:0] last_w;
   logic [DIV_COUNT_WIDTH-1:0] half_w;
   logic wrap_w;
   logic level_nxt;

   function automatic logic [DIV_COUNT_WIDTH-1:0] last_count(input logic [1:0] sel);
      unique case (sel)
         DIVIDE_BY_1: last_count = 3'h0;
         DIVIDE_BY_2: last_count = 3'h1;
         DIVIDE_BY_4: last_count = 3'h3;
         DIVIDE_BY_8: last_count = 3'h7;
      endcase
   endfunction

   assign last_w = last_count(active_select);
   assign half_w = last_w >> 1;
   assign wrap_w = (count_r == last_w);
   assign count_nxt = wrap_w ? 3'h0 : 3'(count_r + 3'h1);
   // Divide by 1 cannot be built from a single-edge register; a toggling level
   // at half rate stands for it and the tick marks every source edge.
   assign level_nxt = (active_select == DIVIDE_BY_1) ? ~sys_clk_level :
      (count_nxt <= half_w);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= 3'h0;
         active_select <= DIVIDE_BY_1;
         sys_clk_level <= 1'b1;
         sys_clk_tick <= 1'b0;
      end else begin
         count_r <= count_nxt;
         sys_clk_level <= level_nxt;
         sys_clk_tick <= wrap_w;
         if (wrap_w) begin
            active_select <= select;
         end
      end
   end
endmodule
`default_nettype wire

// >>> core/system_clock_divider.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// System clock divider with its control register on APB.
module system_clock_divider
   import clock_divider_pkg::*;
#(
   parameter int STANDBY_WAIT_CYCLES = STANDBY_WAIT_DEFAULT
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hw_standby_n,
   input wire logic sw_standby_exit,
   output logic clock_output_pin,
   output logic module_clock_enable,
   output logic standby_wait_done
);
   // ==========================================================================
   // Types and helpers

   // Bus phase as the slave sees it: an answer cycle follows every setup.
   typedef enum logic {
      BUS_IDLE,
      BUS_ANSWER
   } bus_state_t;

   // The exit wait is either idle or counting divided periods.
   typedef enum logic {
      WAIT_IDLE,
      WAIT_COUNT
   } wait_state_t;

   // The register is one aligned word; every other address is refused.
   function automatic logic addr_hit(input logic [31:0] addr);
      addr_hit = (addr == CLOCK_DIVIDE_CONTROL_ADDR);
   endfunction

   // Reserved bits are not stored, so the image always shows them as ones.
   function automatic logic [7:0] reg_image(input logic [1:0] sel);
      reg_image = RESERVED_READ_MASK | {6'h00, sel};
   endfunction

   // ==========================================================================
   // Pin synchronisers

   // Both pins are asynchronous to pclk. Each passes two flip-flops and only
   // the second one is read, so a metastable first stage never fans out.
   localparam int PIN_COUNT = 2;
   localparam int PIN_HW_STANDBY = 0;
   localparam int PIN_SW_EXIT = 1;

   logic [PIN_COUNT-1:0] pin_raw_w;
   logic [PIN_COUNT-1:0] pin_sync_w;
   logic hw_standby_n_sync_w;
   logic exit_sync_w;
   logic exit_seen_r;
   logic exit_rise_w;

   assign pin_raw_w[PIN_HW_STANDBY] = hw_standby_n;
   assign pin_raw_w[PIN_SW_EXIT] = sw_standby_exit;

   for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
      logic meta_r;
      logic sync_r;

      // Both stages clear to zero, so hardware standby is assumed until the
      // pin has been seen high twice.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
         end else begin
            meta_r <= pin_raw_w[i];
            sync_r <= meta_r;
         end
      end

      assign pin_sync_w[i] = sync_r;
   end

   assign hw_standby_n_sync_w = pin_sync_w[PIN_HW_STANDBY];
   assign exit_sync_w = pin_sync_w[PIN_SW_EXIT];

   // The edge detector clears to the idle level of the pin, so no false
   // exit edge follows reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exit_seen_r <= 1'b0;
      end else begin
         exit_seen_r <= exit_sync_w;
      end
   end

   assign exit_rise_w = exit_sync_w && !exit_seen_r;

   // ==========================================================================
   // Control register

   logic [1:0] divide_select_r;
   logic [1:0] divide_select_nxt;
   logic [1:0] write_select_w;
   logic setup_w;
   logic access_w;
   logic hit_w;
   logic write_w;
   logic read_setup_w;
   bus_state_t bus_state_r;
   bus_state_t bus_state_nxt;

   assign setup_w = psel && !penable;
   assign access_w = psel && penable;
   assign hit_w = addr_hit(paddr);
   assign write_w = access_w && (bus_state_r == BUS_ANSWER) && pwrite && hit_w && pstrb[0];
   assign read_setup_w = setup_w && !pwrite && hit_w;

   // Only the low two bits are stored, so writes to reserved bits are dropped.
   assign write_select_w = pwdata[DIVIDE_SELECT_HIGH_BIT:DIVIDE_SELECT_LOW_BIT];
   assign divide_select_nxt = write_w ? write_select_w : divide_select_r;

   // Software standby reaches this block only through its exit pin, which
   // does not touch the register, so the register simply holds across it.
   // Hardware standby forces the reset value.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         divide_select_r <= CLOCK_DIVIDE_CONTROL_RESET[1:0];
      end else if (!hw_standby_n_sync_w) begin
         divide_select_r <= CLOCK_DIVIDE_CONTROL_RESET[1:0];
      end else begin
         divide_select_r <= divide_select_nxt;
      end
   end

   // ==========================================================================
   // Bus phase tracking

   // A write lands only in an access cycle that followed a setup cycle, so a
   // master that skips setup cannot change the ratio.
   always_comb begin
      bus_state_nxt = bus_state_r;
      unique case (bus_state_r)
         BUS_IDLE: begin
            bus_state_nxt = setup_w ? BUS_ANSWER : BUS_IDLE;
         end
         BUS_ANSWER: begin
            bus_state_nxt = setup_w ? BUS_ANSWER : BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_state_r <= BUS_IDLE;
      end else begin
         bus_state_r <= bus_state_nxt;
      end
   end

   // ==========================================================================
   // Bus answer

   // The answer is registered from the setup cycle, which gives zero wait
   // states; ready, error and read data stand for the access cycle only.
   logic ready_nxt;
   logic error_nxt;
   logic [31:0] rdata_nxt;

   assign ready_nxt = setup_w;
   assign error_nxt = setup_w && !hit_w;
   assign rdata_nxt = read_setup_w ? {24'h000000, reg_image(divide_select_r)} : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= ready_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= error_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else begin
         prdata <= rdata_nxt;
      end
   end

   // ==========================================================================
   // Divider

   logic level_w;
   logic tick_w;

   // The divider picks up a new select only at its own period boundary.
   divided_clock_gen u_gen (
      .pclk(pclk),
      .presetn(presetn),
      .select(divide_select_r),
      .sys_clk_level(level_w),
      .sys_clk_tick(tick_w),
      .active_select()
   );

   // ==========================================================================
   // Clock outputs

   // The pin idles high during reset, matching the divider's first phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_output_pin <= 1'b1;
      end else begin
         clock_output_pin <= level_w;
      end
   end

   // On-chip modules advance once per divided period on this enable.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         module_clock_enable <= 1'b0;
      end else begin
         module_clock_enable <= tick_w;
      end
   end

   // ==========================================================================
   // Standby exit wait

   // The wait is counted in divided periods, so its length in time follows
   // the ratio; a fresh exit edge while counting starts the wait again.
   localparam int WAIT_W = $clog2(STANDBY_WAIT_CYCLES + 1);

   wait_state_t wait_state_r;
   wait_state_t wait_state_nxt;
   logic [WAIT_W-1:0] wait_r;
   logic [WAIT_W-1:0] wait_nxt;
   logic last_period_w;
   logic done_nxt;

   assign last_period_w = (wait_r == WAIT_W'(STANDBY_WAIT_CYCLES - 1));

   always_comb begin
      wait_state_nxt = wait_state_r;
      wait_nxt = wait_r;
      done_nxt = 1'b0;
      unique case (wait_state_r)
         WAIT_IDLE: begin
            if (exit_rise_w) begin
               wait_state_nxt = WAIT_COUNT;
               wait_nxt = '0;
            end
         end
         WAIT_COUNT: begin
            if (exit_rise_w) begin
               wait_nxt = '0;
            end else if (tick_w) begin
               if (last_period_w) begin
                  wait_state_nxt = WAIT_IDLE;
                  done_nxt = 1'b1;
               end else begin
                  wait_nxt = WAIT_W'(wait_r + 1'b1);
               end
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_state_r <= WAIT_IDLE;
      end else begin
         wait_state_r <= wait_state_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_r <= '0;
      end else begin
         wait_r <= wait_nxt;
      end
   end

   // The done flag is a single-cycle pulse at the end of the last period.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         standby_wait_done <= 1'b0;
      end else begin
         standby_wait_done <= done_nxt;
      end
   end

   // ==========================================================================
   // Notes for users

   // The divide-by-one setting shows a half-rate toggle on the output pin,
   // since a registered output cannot run at the source clock itself.
   // Software must keep the divided clock inside its operating range; the
   // block accepts every code and does not police the resulting frequency.
endmodule
`default_nettype wire

// >>> verification/system_clock_divider_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ====================================
// Port checks for the clock divider.
module system_clock_divider_sva
   import clock_divider_pkg::*;
#(
   parameter int STANDBY_WAIT_CYCLES = STANDBY_WAIT_DEFAULT
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic hw_standby_n,
   input wire logic sw_standby_exit,
   input wire logic clock_output_pin,
   input wire logic module_clock_enable,
   input wire logic standby_wait_done
);
   logic [3:0] gap_r;
   logic [2:0] run_r;
   // The gap count stays at zero until the first enable, so a partial first period is not judged.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_r <= 4'h0;
         run_r <= 3'h0;
      end else begin
         gap_r <= module_clock_enable ? 4'h1 : gap_r + {3'h0, gap_r != 4'h0};
         run_r <= $changed(clock_output_pin) ? 3'h1 : run_r + 3'h1;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   setup_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
   bad_addr_a: assert property (pready && paddr != CLOCK_DIVIDE_CONTROL_ADDR |->
      pslverr && prdata == 32'h0) else $error("unmapped access taken");
   good_addr_a: assert property (pready && paddr == CLOCK_DIVIDE_CONTROL_ADDR |->
      !pslverr) else $error("mapped access refused");
   ones_read_a: assert property (pready && !pwrite && !pslverr |->
      prdata[31:2] == 30'h3F) else $error("reserved bits wrong");
   enable_gap_a: assert property (module_clock_enable && gap_r != 4'h0 |->
      gap_r inside {4'h1, 4'h2, 4'h4, 4'h8}) else $error("bad divided period");
   pin_phase_a: assert property (run_r <= 3'h4) else $error("output pin phase too long");
   done_pulse_a: assert property (standby_wait_done |=> !standby_wait_done) else $error("done held");
   wait_hold_a: assert property ($rose(sw_standby_exit) |-> !standby_wait_done [*4])
      else $error("exit wait too short");
   cover property (pslverr);
   cover property (module_clock_enable && gap_r == 4'h8);
   cover property (standby_wait_done);
endmodule
`default_nettype wire

// >>> verification/module_tick_timer.sv
`timescale 1ns/1ns
`default_nettype none
// ====================================
// A timer of an on-chip module.
module module_tick_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   output logic [15:0] ticks
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ticks <= 16'h0;
      end else if (tick) begin
         ticks <= ticks + 16'h1;
      end
   end
endmodule
`default_nettype wire

// >>> verification/system_clock_divider_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ====================================
// Bench for the system clock divider.
module system_clock_divider_tb;
   import clock_divider_pkg::*;
   localparam int STANDBY_WAIT_CYCLES = 4;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hw_standby_n = 1;
   logic sw_standby_exit = 0, pready, pslverr, clock_output_pin, module_clock_enable;
   logic standby_wait_done, err;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic [15:0] ticks, t0;
   int fails = 0, tests_run = 0, model_r = 'hFC, code, c;
   system_clock_divider #(.STANDBY_WAIT_CYCLES(STANDBY_WAIT_CYCLES)) i_dut (.*);
   module_tick_timer i_timer (.pclk(pclk), .presetn(presetn), .tick(module_clock_enable),
      .ticks(ticks));
   initial forever #2 pclk = ~pclk;
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wait_en;
      do @(posedge pclk); while (module_clock_enable !== 1'b1);
   endtask
   task automatic finish_test;
      if (fails == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #80000;
      fails++;
      finish_test();
   end
   initial begin
      void'($urandom(30919));
      repeat (2) @(posedge pclk);
      presetn <= 1;
      apb(0, CLOCK_DIVIDE_CONTROL_ADDR, 0);
      chk("reset value", model_r, rd);
      for (code = 0; code < 4; code++) begin
         apb(1, CLOCK_DIVIDE_CONTROL_ADDR, ($urandom() & 32'hFFFFFFFC) | code);
         model_r = 'hFC | code;
         apb(1, $urandom() | 32'h100000, 3 - code);
         chk("unmapped error", 1, err);
         apb(0, CLOCK_DIVIDE_CONTROL_ADDR, 0);
         chk("control read", model_r, rd);
         chk("mapped error", 0, err);
         repeat (2) wait_en();
         t0 = ticks;
         repeat (64) @(posedge pclk);
         chk("timer ticks", 64 >> code, ticks - t0);
      end
      // Exit wait is only bounded loosely, since the start may fall mid-period.
      sw_standby_exit <= 1;
      c = 0;
      do begin
         @(posedge pclk);
         c++;
      end while (standby_wait_done !== 1'b1 && c < 200);
      chk("exit wait", 1, c > 24 && c <= 46);
      sw_standby_exit <= 0;
      apb(0, CLOCK_DIVIDE_CONTROL_ADDR, 0);
      chk("kept over standby", model_r, rd);
      hw_standby_n <= 0;
      repeat (4) @(posedge pclk);
      hw_standby_n <= 1;
      repeat (3) @(posedge pclk);
      apb(0, CLOCK_DIVIDE_CONTROL_ADDR, 0);
      chk("hardware standby", 'hFC, rd);
      finish_test();
   end
endmodule
bind system_clock_divider system_clock_divider_sva
   #(.STANDBY_WAIT_CYCLES(STANDBY_WAIT_CYCLES)) i_sva (.*);
`default_nettype wire
